// ==== hdl/dsr_pkg.sv ====
// package: register map, field layout and fixed values of the deserializer status and identity bank
package dsr_pkg;

   // bus geometry
   localparam int          DSR_ADDR_W       = 8;
   localparam int          DSR_DATA_W       = 32;
   localparam int          DSR_IDX_W        = 6;
   localparam int          DSR_IDX_LSB      = 2;
   localparam int          DSR_REG_W        = 8;

   // register indices (byte address is four times the index)
   localparam logic [5:0]  DSR_IDX_LINE     = 6'h14;
   localparam logic [5:0]  DSR_IDX_RSV_A    = 6'h15;
   localparam logic [5:0]  DSR_IDX_RSV_B    = 6'h16;
   localparam logic [5:0]  DSR_IDX_RSV_C    = 6'h17;
   localparam logic [5:0]  DSR_IDX_RSV_D    = 6'h18;
   localparam logic [5:0]  DSR_IDX_RSV_E    = 6'h19;
   localparam logic [5:0]  DSR_IDX_RSV_F    = 6'h1A;
   localparam logic [5:0]  DSR_IDX_RSV_G    = 6'h1B;
   localparam logic [5:0]  DSR_IDX_RSV_H    = 6'h1C;
   localparam logic [5:0]  DSR_IDX_PINS     = 6'h1D;
   localparam logic [5:0]  DSR_IDX_ID       = 6'h1E;
   localparam logic [5:0]  DSR_IDX_CAPREV   = 6'h1F;
   localparam logic [5:0]  DSR_IDX_CTRL     = 6'h20;

   // fixed reserved patterns
   localparam logic [7:0]  DSR_RSV_A_VAL    = 8'h20;
   localparam logic [7:0]  DSR_RSV_B_VAL    = 8'h30;
   localparam logic [7:0]  DSR_RSV_C_VAL    = 8'h54;
   localparam logic [7:0]  DSR_RSV_D_VAL    = 8'h30;
   localparam logic [7:0]  DSR_RSV_E_VAL    = 8'hC8;
   localparam logic [7:0]  DSR_RSV_ZERO     = 8'h00;

   // line status register fields
   localparam int          DSR_PASS_BIT     = 7;
   localparam int          DSR_NEG_LSB      = 2;
   localparam int          DSR_POS_LSB      = 0;

   // cable wire state codes
   localparam logic [1:0]  DSR_WIRE_SHORT_SUPPLY = 2'h0;
   localparam logic [1:0]  DSR_WIRE_SHORT_GND    = 2'h1;
   localparam logic [1:0]  DSR_WIRE_NORMAL       = 2'h2;
   localparam logic [1:0]  DSR_WIRE_OPEN         = 2'h3;

   // pin mirror register: four pin bits in the upper nibble
   localparam int          DSR_PINS_LSB     = 4;

   // capability / revision register fields
   localparam int          DSR_CAP_BIT      = 4;
   localparam int          DSR_REV_LSB      = 0;

   // control register fields
   localparam int          DSR_CTRL_RUN_BIT = 0;

   // axi responses
   localparam logic [1:0]  DSR_RESP_OKAY    = 2'h0;
   localparam logic [1:0]  DSR_RESP_DECERR  = 2'h3;

   // reset values
   localparam logic [31:0] DSR_WORD_ZERO    = 32'h0000_0000;
   localparam logic [7:0]  DSR_ADDR_ZERO    = 8'h00;
   localparam logic [3:0]  DSR_STRB_ZERO    = 4'h0;
   localparam logic [3:0]  DSR_PINS_ZERO    = 4'h0;

endpackage

// ==== hdl/dsr_stat_if.sv ====
// interface: status snapshot and test control between the bank and its capture logic
`timescale 1ns/1ps
interface dsr_stat_if;
   logic       pass_flag;
   logic [1:0] neg_code;
   logic [1:0] pos_code;
   logic [3:0] pin_levels;
   logic       test_run;
   logic       test_start;

   modport cap  (output pass_flag, output neg_code, output pos_code, output pin_levels,
                 input test_run, input test_start);
   modport bank (input pass_flag, input neg_code, input pos_code, input pin_levels,
                 output test_run, output test_start);
endinterface

// ==== hdl/dsr_stat_capture.sv ====
// module: captures test result, wire fault codes and mode pin levels into flip-flops
`timescale 1ns/1ps
module dsr_stat_capture
   import dsr_pkg::*;
(
   input  logic       aclk,
   input  logic       aresetn,
   input  logic       seq_test_done,
   input  logic       seq_test_ok,
   input  logic [1:0] neg_wire_fault_in,
   input  logic [1:0] pos_wire_fault_in,
   input  logic       cable_type_pin_level,
   input  logic       coax_select_state,
   input  logic       control_port_select_level,
   input  logic       local_ctrl_channel_enable_level,
   dsr_stat_if.cap    stat
);

   logic       pass_reg;
   logic       pass_next;
   logic [1:0] neg_reg;
   logic [1:0] pos_reg;
   logic [3:0] pins_reg;
   wire        pass_set;
   wire        pass_clr;

   // only a completed and successful run sets the flag; a new start or a failed run clears it
   assign pass_set  = stat.test_run & seq_test_done & seq_test_ok;
   assign pass_clr  = stat.test_start | (seq_test_done & ~seq_test_ok);
   // set wins so a pass landing with a restart is not lost
   assign pass_next = pass_set | (pass_reg & ~pass_clr);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pass_reg <= 1'b0;
         neg_reg  <= DSR_WIRE_NORMAL;
         pos_reg  <= DSR_WIRE_NORMAL;
         pins_reg <= DSR_PINS_ZERO;
      end else begin
         pass_reg <= pass_next;
         neg_reg  <= neg_wire_fault_in;
         pos_reg  <= pos_wire_fault_in;
         pins_reg <= {cable_type_pin_level, coax_select_state,
                      control_port_select_level, local_ctrl_channel_enable_level};
      end
   end

   assign stat.pass_flag  = pass_reg;
   assign stat.neg_code   = neg_reg;
   assign stat.pos_code   = pos_reg;
   assign stat.pin_levels = pins_reg;

endmodule

// ==== hdl/dsr_status_bank.sv ====
// module: axi4-lite register bank for line status, pin mirror, reserved and identity registers
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module dsr_status_bank
   import dsr_pkg::*;
#(
   parameter logic [7:0] DEVICE_ID      = 8'h5A,   // arbitrary neutral value
   parameter logic [3:0] DEVICE_REV     = 4'h1,    // arbitrary neutral value
   parameter logic       PROTECT_CAPABLE = 1'b0
)
(
   input  logic        aclk,
   input  logic        aresetn,
   input  logic [7:0]  s_axil_awaddr,
   input  logic [2:0]  s_axil_awprot,
   input  logic        s_axil_awvalid,
   output logic        s_axil_awready,
   input  logic [31:0] s_axil_wdata,
   input  logic [3:0]  s_axil_wstrb,
   input  logic        s_axil_wvalid,
   output logic        s_axil_wready,
   output logic [1:0]  s_axil_bresp,
   output logic        s_axil_bvalid,
   input  logic        s_axil_bready,
   input  logic [7:0]  s_axil_araddr,
   input  logic [2:0]  s_axil_arprot,
   input  logic        s_axil_arvalid,
   output logic        s_axil_arready,
   output logic [31:0] s_axil_rdata,
   output logic [1:0]  s_axil_rresp,
   output logic        s_axil_rvalid,
   input  logic        s_axil_rready,
   input  logic        seq_test_done,
   input  logic        seq_test_ok,
   input  logic [1:0]  neg_wire_fault_in,
   input  logic [1:0]  pos_wire_fault_in,
   input  logic        cable_type_pin_level,
   input  logic        coax_select_state,
   input  logic        control_port_select_level,
   input  logic        local_ctrl_channel_enable_level,
   output logic        seq_test_run
);

   // ------------------------------------------------------------------
   // register index helpers
   // ------------------------------------------------------------------

   function automatic logic [5:0] idx_of(input logic [7:0] addr);
      idx_of = addr[DSR_ADDR_W-1:DSR_IDX_LSB];
   endfunction

   function automatic logic idx_mapped(input logic [5:0] idx);
      idx_mapped = (idx >= DSR_IDX_LINE) && (idx <= DSR_IDX_CTRL);
   endfunction

   // ------------------------------------------------------------------
   // field placement: each field sits at its named position, every other bit reads zero
   // ------------------------------------------------------------------

   function automatic logic [7:0] place_line(input logic       pass,
                                             input logic [1:0] neg,
                                             input logic [1:0] pos);
      logic [7:0] b;
      b = DSR_RSV_ZERO;
      b = b | (DSR_REG_W'(pass) << DSR_PASS_BIT);
      b = b | (DSR_REG_W'(neg) << DSR_NEG_LSB);
      b = b | (DSR_REG_W'(pos) << DSR_POS_LSB);
      place_line = b;
   endfunction

   function automatic logic [7:0] place_pins(input logic [3:0] levels);
      place_pins = DSR_REG_W'(levels) << DSR_PINS_LSB;
   endfunction

   function automatic logic [7:0] place_caprev(input logic       cap,
                                               input logic [3:0] rev);
      logic [7:0] b;
      b = DSR_RSV_ZERO;
      b = b | (DSR_REG_W'(cap) << DSR_CAP_BIT);
      b = b | (DSR_REG_W'(rev) << DSR_REV_LSB);
      place_caprev = b;
   endfunction

   function automatic logic [7:0] place_ctrl(input logic run);
      place_ctrl = DSR_REG_W'(run) << DSR_CTRL_RUN_BIT;
   endfunction

   // registers are one byte wide; the upper bus lanes always read zero
   function automatic logic [31:0] to_word(input logic [7:0] b);
      to_word = DSR_DATA_W'(b);
   endfunction

   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------

   dsr_stat_if stat ();

   // byte lane of the control word that carries the run bit
   localparam int CTRL_LANE = DSR_CTRL_RUN_BIT / DSR_REG_W;

   logic        awready_reg;
   logic        wready_reg;
   logic        bvalid_reg;
   logic [1:0]  bresp_reg;
   logic        arready_reg;
   logic        rvalid_reg;
   logic [1:0]  rresp_reg;
   logic [31:0] rdata_reg;

   logic        aw_held_reg;
   logic [7:0]  aw_addr_reg;
   logic        w_held_reg;
   logic [31:0] w_data_reg;
   logic [3:0]  w_strb_reg;

   logic        run_reg;
   logic        start_reg;

   wire         aw_take;
   wire         w_take;
   wire         wr_fire;
   wire         b_done;
   wire         ar_take;
   wire         r_done;
   wire  [5:0]  wr_idx;
   wire  [5:0]  rd_idx;
   wire         wr_hit;
   wire         rd_hit;
   wire         wr_ctrl;
   wire         run_next;
   wire  [7:0]  line_byte;
   wire  [7:0]  pins_byte;
   wire  [7:0]  caprev_byte;
   wire  [7:0]  ctrl_byte;
   logic [7:0]  rd_byte;

   // ------------------------------------------------------------------
   // handshake decode
   // ------------------------------------------------------------------

   assign aw_take  = s_axil_awvalid & awready_reg;
   assign w_take   = s_axil_wvalid  & wready_reg;
   // write proceeds once both halves are held and no response is outstanding
   assign wr_fire  = aw_held_reg & w_held_reg & ~bvalid_reg;
   assign b_done   = bvalid_reg & s_axil_bready;
   assign ar_take  = s_axil_arvalid & arready_reg;
   assign r_done   = rvalid_reg & s_axil_rready;

   assign wr_idx   = idx_of(aw_addr_reg);
   assign rd_idx   = idx_of(s_axil_araddr);
   assign wr_hit   = idx_mapped(wr_idx);
   assign rd_hit   = idx_mapped(rd_idx);

   // only the control register accepts data; every other mapped index drops it
   assign wr_ctrl  = wr_fire & (wr_idx == DSR_IDX_CTRL) & w_strb_reg[CTRL_LANE];
   assign run_next = wr_ctrl ? w_data_reg[DSR_CTRL_RUN_BIT] : run_reg;

   // ------------------------------------------------------------------
   // read data assembly
   // ------------------------------------------------------------------

   assign line_byte   = place_line(stat.pass_flag,
                                   stat.neg_code,
                                   stat.pos_code);
   assign pins_byte   = place_pins(stat.pin_levels);
   assign caprev_byte = place_caprev(PROTECT_CAPABLE, DEVICE_REV);
   assign ctrl_byte   = place_ctrl(run_reg);

   always_comb begin
      case (rd_idx)
         DSR_IDX_LINE:   rd_byte = line_byte;
         DSR_IDX_RSV_A:  rd_byte = DSR_RSV_A_VAL;
         DSR_IDX_RSV_B:  rd_byte = DSR_RSV_B_VAL;
         DSR_IDX_RSV_C:  rd_byte = DSR_RSV_C_VAL;
         DSR_IDX_RSV_D:  rd_byte = DSR_RSV_D_VAL;
         DSR_IDX_RSV_E:  rd_byte = DSR_RSV_E_VAL;
         DSR_IDX_RSV_F,
         DSR_IDX_RSV_G,
         DSR_IDX_RSV_H:  rd_byte = DSR_RSV_ZERO;
         DSR_IDX_PINS:   rd_byte = pins_byte;
         DSR_IDX_ID:     rd_byte = DEVICE_ID;
         DSR_IDX_CAPREV: rd_byte = caprev_byte;
         DSR_IDX_CTRL:   rd_byte = ctrl_byte;
         default:        rd_byte = DSR_RSV_ZERO;
      endcase
   end

   // ------------------------------------------------------------------
   // write channel: address and data are taken in either order
   // ------------------------------------------------------------------

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_reg <= 1'b1;
         aw_held_reg <= 1'b0;
         aw_addr_reg <= DSR_ADDR_ZERO;
      end else if (aw_take) begin
         awready_reg <= 1'b0;
         aw_held_reg <= 1'b1;
         aw_addr_reg <= s_axil_awaddr;
      end else if (wr_fire) begin
         aw_held_reg <= 1'b0;
      end else if (b_done) begin
         awready_reg <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wready_reg <= 1'b1;
         w_held_reg <= 1'b0;
         w_data_reg <= DSR_WORD_ZERO;
         w_strb_reg <= DSR_STRB_ZERO;
      end else if (w_take) begin
         wready_reg <= 1'b0;
         w_held_reg <= 1'b1;
         w_data_reg <= s_axil_wdata;
         w_strb_reg <= s_axil_wstrb;
      end else if (wr_fire) begin
         w_held_reg <= 1'b0;
      end else if (b_done) begin
         wready_reg <= 1'b1;
      end
   end

   // readies re-arm only after the response, so one write at most is in flight
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_reg <= 1'b0;
         bresp_reg  <= DSR_RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_reg <= 1'b1;
         bresp_reg  <= wr_hit ? DSR_RESP_OKAY : DSR_RESP_DECERR;
      end else if (b_done) begin
         bvalid_reg <= 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // read channel: data is sampled at the address edge, so reads are side-effect free
   // ------------------------------------------------------------------

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_reg <= 1'b1;
         rvalid_reg  <= 1'b0;
         rresp_reg   <= DSR_RESP_OKAY;
         rdata_reg   <= DSR_WORD_ZERO;
      end else if (ar_take) begin
         arready_reg <= 1'b0;
         rvalid_reg  <= 1'b1;
         rresp_reg   <= rd_hit ? DSR_RESP_OKAY : DSR_RESP_DECERR;
         rdata_reg   <= rd_hit ? to_word(rd_byte) : DSR_WORD_ZERO;
      end else if (r_done) begin
         arready_reg <= 1'b1;
         rvalid_reg  <= 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // test control: a 0 to 1 write of the run bit marks a fresh test
   // ------------------------------------------------------------------

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         run_reg   <= 1'b0;
         start_reg <= 1'b0;
      end else begin
         run_reg   <= run_next;
         start_reg <= run_next & ~run_reg;
      end
   end

   assign stat.test_run   = run_reg;
   assign stat.test_start = start_reg;

   dsr_stat_capture u_capture (
      .aclk                            (aclk),
      .aresetn                         (aresetn),
      .seq_test_done                   (seq_test_done),
      .seq_test_ok                     (seq_test_ok),
      .neg_wire_fault_in               (neg_wire_fault_in),
      .pos_wire_fault_in               (pos_wire_fault_in),
      .cable_type_pin_level            (cable_type_pin_level),
      .coax_select_state               (coax_select_state),
      .control_port_select_level       (control_port_select_level),
      .local_ctrl_channel_enable_level (local_ctrl_channel_enable_level),
      .stat                            (stat)
   );

   // ------------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------------

   assign s_axil_awready = awready_reg;
   assign s_axil_wready  = wready_reg;
   assign s_axil_bvalid  = bvalid_reg;
   assign s_axil_bresp   = bresp_reg;
   assign s_axil_arready = arready_reg;
   assign s_axil_rvalid  = rvalid_reg;
   assign s_axil_rresp   = rresp_reg;
   assign s_axil_rdata   = rdata_reg;
   assign seq_test_run   = run_reg;

endmodule

// ==== tb/dsr_status_bank_checker.sv ====
// checker: read-path properties of the status and identity bank
`timescale 1ns/1ps
module dsr_status_bank_checker
   import dsr_pkg::*;
#(
   parameter logic [7:0] DEVICE_ID       = 8'h5A,
   parameter logic [3:0] DEVICE_REV      = 4'h1,
   parameter logic       PROTECT_CAPABLE = 1'b0
)
(
   input logic        aclk,
   input logic        aresetn,
   input logic [7:0]  s_axil_araddr,
   input logic        s_axil_arvalid,
   input logic        s_axil_arready,
   input logic [31:0] s_axil_rdata,
   input logic [1:0]  s_axil_rresp,
   input logic        s_axil_rvalid,
   input logic        seq_test_done,
   input logic        seq_test_ok,
   input logic [1:0]  neg_wire_fault_in,
   input logic [1:0]  pos_wire_fault_in,
   input logic        cable_type_pin_level,
   input logic        coax_select_state,
   input logic        control_port_select_level,
   input logic        local_ctrl_channel_enable_level,
   input logic        seq_test_run
);
   logic [5:0] rd_idx;
   logic       run_d;
   logic       pass_exp;
   logic       pass_at_take;
   logic [7:0] rsv_exp;
   wire        ar_take  = s_axil_arvalid && s_axil_arready;
   wire [3:0]  pins_now = {cable_type_pin_level, coax_select_state, control_port_select_level,
                           local_ctrl_channel_enable_level};
   wire        rd_line  = s_axil_rvalid && (rd_idx == DSR_IDX_LINE);
   wire        rd_id    = s_axil_rvalid && (rd_idx == DSR_IDX_ID);
   wire        rd_cap   = s_axil_rvalid && (rd_idx == DSR_IDX_CAPREV);
   wire        rd_rsv   = s_axil_rvalid && (rd_idx >= DSR_IDX_RSV_A) && (rd_idx <= DSR_IDX_RSV_H);
   assign rsv_exp = (rd_idx == DSR_IDX_RSV_A) ? 8'h20 :
                    (rd_idx == DSR_IDX_RSV_B || rd_idx == DSR_IDX_RSV_D) ? 8'h30 :
                    (rd_idx == DSR_IDX_RSV_C) ? 8'h54 :
                    (rd_idx == DSR_IDX_RSV_E) ? 8'hC8 : 8'h00;

   // expected pass flag: a successful end while running sets it, a fresh start or a failed end clears it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_idx       <= 6'h00;
         run_d        <= 1'b0;
         pass_exp     <= 1'b0;
         pass_at_take <= 1'b0;
      end else begin
         run_d <= seq_test_run;
         if (ar_take) rd_idx <= s_axil_araddr[7:2];
         if (ar_take) pass_at_take <= pass_exp;
         if (seq_test_run && seq_test_done && seq_test_ok) pass_exp <= 1'b1;
         else if ((seq_test_run && !run_d) || (seq_test_done && !seq_test_ok)) pass_exp <= 1'b0;
      end
   end

   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // inputs need a settled history because they pass a capture stage before the bank
   sequence s_steady_line;
      (aresetn && $stable(neg_wire_fault_in) && $stable(pos_wire_fault_in))[*3]
         ##0 (ar_take && s_axil_araddr[7:2] == DSR_IDX_LINE);
   endsequence
   sequence s_steady_pins;
      (aresetn && $stable(pins_now))[*3] ##0 (ar_take && s_axil_araddr[7:2] == DSR_IDX_PINS);
   endsequence

   a_neg_code: assert property (s_steady_line |=> s_axil_rdata[3:2] == $past(neg_wire_fault_in))
      else $error("negative wire code differs from input");
   a_pos_code: assert property (s_steady_line |=> s_axil_rdata[1:0] == $past(pos_wire_fault_in))
      else $error("positive wire code differs from input");
   a_pins_mirror: assert property (s_steady_pins |=> s_axil_rdata == {24'h0, $past(pins_now), 4'h0})
      else $error("pin mirror differs from pin levels");
   a_line_rsvd_zero: assert property (rd_line |-> s_axil_rdata[6:4] == 3'h0 && s_axil_rdata[31:8] == 24'h0)
      else $error("line status reserved bits not zero");
   a_pass_cause: assert property (rd_line |-> s_axil_rdata[7] == pass_at_take)
      else $error("pass flag differs from test history");
   a_id_fixed: assert property (rd_id |-> s_axil_rdata == {24'h0, DEVICE_ID})
      else $error("identifier read wrong");
   a_cap_rev: assert property (rd_cap |-> s_axil_rdata == {24'h0, 3'h0, PROTECT_CAPABLE, DEVICE_REV})
      else $error("capability or revision read wrong");
   a_rsvd_pattern: assert property (rd_rsv |-> s_axil_rdata == {24'h0, rsv_exp} && s_axil_rresp == DSR_RESP_OKAY)
      else $error("reserved register pattern wrong");
endmodule
bind dsr_status_bank dsr_status_bank_checker #(.DEVICE_ID(DEVICE_ID), .DEVICE_REV(DEVICE_REV),
   .PROTECT_CAPABLE(PROTECT_CAPABLE)) u_chk (.aclk, .aresetn, .s_axil_araddr, .s_axil_arvalid,
   .s_axil_arready, .s_axil_rdata, .s_axil_rresp, .s_axil_rvalid, .seq_test_done, .seq_test_ok,
   .neg_wire_fault_in, .pos_wire_fault_in, .cable_type_pin_level, .coax_select_state,
   .control_port_select_level, .local_ctrl_channel_enable_level, .seq_test_run);

// ==== tb/dsr_status_bank_tb_top.sv ====
// testbench: bus reads and writes of the status bank compared with a behavioural model
`timescale 1ns/1ps
module dsr_status_bank_tb_top;
   import dsr_pkg::*;
   localparam logic [7:0] TB_ID  = 8'hA7; // arbitrary value
   localparam logic [3:0] TB_REV = 4'h9;  // arbitrary value
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [7:0]  s_axil_awaddr = 8'h00, s_axil_araddr = 8'h00;
   logic [2:0]  s_axil_awprot = 3'h0, s_axil_arprot = 3'h0;
   logic        s_axil_awvalid = 1'b0, s_axil_wvalid = 1'b0, s_axil_bready = 1'b0;
   logic        s_axil_arvalid = 1'b0, s_axil_rready = 1'b0;
   logic [31:0] s_axil_wdata = 32'h0, s_axil_rdata;
   logic [3:0]  s_axil_wstrb = 4'h0;
   logic        s_axil_awready, s_axil_wready, s_axil_bvalid, s_axil_arready, s_axil_rvalid;
   logic [1:0]  s_axil_bresp, s_axil_rresp, resp;
   logic        seq_test_done = 1'b0, seq_test_ok = 1'b0, seq_test_run;
   logic [1:0]  neg_wire_fault_in = 2'h2, pos_wire_fault_in = 2'h2;
   logic        cable_type_pin_level = 1'b0, coax_select_state = 1'b0;
   logic        control_port_select_level = 1'b0, local_ctrl_channel_enable_level = 1'b0;
   logic        m_pass = 1'b0, m_run = 1'b0;
   logic [3:0]  wr_strb = 4'hF;
   logic [31:0] data;
   int          failures = 0, n_tests = 0;

   always #10 aclk = ~aclk;

   dsr_status_bank #(.DEVICE_ID(TB_ID), .DEVICE_REV(TB_REV), .PROTECT_CAPABLE(1'b1)) DUT (
      .aclk, .aresetn, .s_axil_awaddr, .s_axil_awprot, .s_axil_awvalid, .s_axil_awready,
      .s_axil_wdata, .s_axil_wstrb, .s_axil_wvalid, .s_axil_wready, .s_axil_bresp, .s_axil_bvalid,
      .s_axil_bready, .s_axil_araddr, .s_axil_arprot, .s_axil_arvalid, .s_axil_arready, .s_axil_rdata,
      .s_axil_rresp, .s_axil_rvalid, .s_axil_rready, .seq_test_done, .seq_test_ok, .neg_wire_fault_in,
      .pos_wire_fault_in, .cable_type_pin_level, .coax_select_state, .control_port_select_level,
      .local_ctrl_channel_enable_level, .seq_test_run);

   function automatic logic [31:0] mdl(input logic [5:0] i);
      logic [7:0] v;
      case (i)
         6'h14: v = {m_pass, 3'h0, neg_wire_fault_in, pos_wire_fault_in};
         6'h15: v = 8'h20;
         6'h16, 6'h18: v = 8'h30;
         6'h17: v = 8'h54;
         6'h19: v = 8'hC8;
         6'h1D: v = {cable_type_pin_level, coax_select_state, control_port_select_level,
                     local_ctrl_channel_enable_level, 4'h0};
         6'h1E: v = TB_ID;
         6'h1F: v = {3'h0, 1'b1, TB_REV};
         6'h20: v = {7'h00, m_run};
         default: v = 8'h00;
      endcase
      return {24'h0, v};
   endfunction

   function automatic logic [31:0] mresp(input logic [5:0] i);
      return (i >= 6'h14 && i <= 6'h20) ? 32'h0 : 32'h3;
   endfunction

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         failures++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask

   // every handshake is judged at the rising edge where it happens; signals change right after it
   task automatic axi_wr(input logic [5:0] i, input logic [31:0] d);
      int n;
      bit at;
      bit wt;
      bit bt;
      n = 0;
      bt = 0;
      @(posedge aclk);
      s_axil_awaddr <= {i, 2'b00};
      s_axil_wdata <= d;
      s_axil_wstrb <= wr_strb;
      s_axil_awvalid <= 1'b1;
      s_axil_wvalid <= 1'b1;
      s_axil_bready <= 1'b1;
      while (!bt && n < 100) begin
         @(posedge aclk);
         at = s_axil_awvalid && s_axil_awready;
         wt = s_axil_wvalid && s_axil_wready;
         bt = s_axil_bvalid && s_axil_bready;
         resp = s_axil_bresp;
         if (at) s_axil_awvalid <= 1'b0;
         if (wt) s_axil_wvalid <= 1'b0;
         if (bt) s_axil_bready <= 1'b0;
         n++;
      end
      chk("bvalid", 32'h1, {31'h0, bt});
      chk("bresp", mresp(i), {30'h0, resp});
      if (i == 6'h20 && wr_strb[0]) begin
         if (d[0] && !m_run) m_pass = 1'b0;
         m_run = d[0];
      end
   endtask

   task automatic rd_chk(input logic [5:0] i);
      int n;
      bit art;
      bit rt;
      n = 0;
      rt = 0;
      @(posedge aclk);
      s_axil_araddr <= {i, 2'b00};
      s_axil_arvalid <= 1'b1;
      s_axil_rready <= 1'b1;
      while (!rt && n < 100) begin
         @(posedge aclk);
         art = s_axil_arvalid && s_axil_arready;
         rt = s_axil_rvalid && s_axil_rready;
         data = s_axil_rdata;
         resp = s_axil_rresp;
         if (art) s_axil_arvalid <= 1'b0;
         if (rt) s_axil_rready <= 1'b0;
         n++;
      end
      chk("rvalid", 32'h1, {31'h0, rt});
      chk("rdata", mdl(i), data);
      chk("rresp", mresp(i), {30'h0, resp});
   endtask

   task automatic pulse(input logic ok);
      @(posedge aclk);
      seq_test_done <= 1'b1;
      seq_test_ok <= ok;
      @(posedge aclk);
      seq_test_done <= 1'b0;
      // a failed end clears the flag whether or not a test is running
      if (!ok) m_pass = 1'b0;
      else if (m_run) m_pass = 1'b1;
   endtask

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   initial begin
      #(20000 * 20);
      failures++;
      give_verdict();
   end

   initial begin
      void'($urandom(63));
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 'h13; i <= 'h21; i++) rd_chk(6'(i));
      $display("test reset values done");
      for (int k = 0; k < 16; k++) begin
         @(posedge aclk);
         {neg_wire_fault_in, pos_wire_fault_in} <= 4'(k);
         {cable_type_pin_level, coax_select_state, control_port_select_level,
          local_ctrl_channel_enable_level} <= 4'($urandom);
         // let the inputs settle so the checker's steady-history properties are exercised
         repeat (2) @(posedge aclk);
         rd_chk(6'h14);
         rd_chk(6'h1D);
      end
      $display("test wire codes and pin mirror done");
      pulse(1'b1);
      rd_chk(6'h14);
      axi_wr(6'h20, 32'h1);
      pulse(1'b1);
      rd_chk(6'h14);
      pulse(1'b0);
      rd_chk(6'h14);
      pulse(1'b1);
      axi_wr(6'h20, 32'h0);
      rd_chk(6'h14);
      axi_wr(6'h20, 32'h1);
      rd_chk(6'h14);
      chk("seq_test_run", {31'h0, m_run}, {31'h0, seq_test_run});
      pulse(1'b1);
      axi_wr(6'h20, 32'h0);
      pulse(1'b0);
      rd_chk(6'h14);
      wr_strb = 4'hE;
      axi_wr(6'h20, 32'h1);
      rd_chk(6'h20);
      $display("test pass flag done");
      for (int i = 'h14; i <= 'h21; i++) begin
         wr_strb = 4'($urandom);
         axi_wr(6'(i), $urandom);
      end
      for (int i = 'h14; i <= 'h21; i++) rd_chk(6'(i));
      $display("test read-only writes done");
      give_verdict();
   end
endmodule
